/* hdl/flash_array.sv */
// flash array storage: one write port, one read port with registered data
// assumes: a single clock; contents are not cleared by reset
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_cfg.svh"

module flash_array #(
  parameter int WORDS = `FP_WORDS,
  parameter int AW = `FP_ADDR_W
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] mem [WORDS];

  initial begin
    if (WORDS != (1 << AW)) begin
      $error("flash_array: WORDS must equal 2**AW");
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

/* hdl/flash_block_protection.sv */
// flash block protection: per-request checks in front of the storage array
// assumes: one requester at a time, req held only one cycle, core_clk 50 MHz
//
// Overview of operation
// - 64 KB flash, 1 KB blocks erased independently
// - erased block reads back all ones
// - protection set per 2 KB block pair
// - each pair open, read-only or execute-only
// - read-only refuses program and erase, allows reads
// - execute-only refuses writes, serves only fetches
// - execute-only hides data from data and debug reads
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_cfg.svh"

module flash_block_protection
  import flash_prot_pkg::*;
#(
  parameter int AW = `FP_ADDR_W,
  parameter int UNITS = `FP_UNITS
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic req,
  input wire flash_op_e op,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic prot_wr,
  input wire logic [`FP_UNIT_W-1:0] prot_unit,
  input wire prot_level_t prot_level,
  output logic busy,
  output logic done,
  output logic denied,
  output logic [31:0] rdata
);
  initial begin
    if (AW != `FP_ADDR_W || UNITS != `FP_UNITS) begin
      $error("flash_block_protection: geometry is fixed at 64 KB");
    end
  end

  typedef enum logic [1:0] {st_idle, st_read, st_erase} state_e;

  state_e state;
  prot_level_t prot [UNITS];
  logic [`FP_BLOCK_W-1:0] erase_block;
  logic [7:0] erase_ix;
  logic rd_pending;
  logic arr_wr;
  logic [AW-1:0] arr_waddr;
  logic [31:0] arr_wdata;
  logic [31:0] arr_rdata;
  prot_level_t lvl;
  logic refuse;

  function automatic logic [`FP_UNIT_W-1:0] unit_of(input logic [AW-1:0] a);
    return a[AW-1:`FP_UNIT_LSB];
  endfunction

  // ------------------------------------------------------------------
  // access check
  // ------------------------------------------------------------------
  assign lvl = prot[unit_of(addr)];
  always_comb begin
    refuse = 1'b0;
    unique case (op)
      op_program, op_erase: refuse = (lvl != `FP_PROT_OPEN);
      op_data_read, op_debug_read: refuse = (lvl == `FP_PROT_XO);
      op_fetch: refuse = 1'b0;
      default: refuse = 1'b1;
    endcase
  end

  // ------------------------------------------------------------------
  // protection table
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < UNITS; i++) begin
        prot[i] <= `FP_PROT_OPEN;
      end
    end else if (prot_wr) begin
      prot[prot_unit] <= prot_level;
    end
  end

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= st_idle;
      erase_block <= '0;
      erase_ix <= `FP_WORD_ZERO_IX;
    end else begin
      unique case (state)
        st_idle: begin
          if (req && !refuse) begin
            if (op == op_erase) begin
              state <= st_erase;
              erase_block <= addr[AW-1:`FP_BLOCK_LSB];
              erase_ix <= `FP_WORD_ZERO_IX;
            end else if (op != op_program) begin
              state <= st_read;
            end
          end
        end
        st_read: state <= st_idle;
        st_erase: begin
          erase_ix <= erase_ix + 8'h01;
          if (erase_ix == `FP_WORD_LAST_IX) begin
            state <= st_idle;
          end
        end
      endcase
    end
  end

  // erase only touches words of the chosen 1 KB block
  always_comb begin
    arr_wr = 1'b0;
    arr_waddr = addr;
    arr_wdata = wdata;
    if (state == st_erase) begin
      arr_wr = 1'b1;
      arr_waddr = {erase_block, erase_ix};
      arr_wdata = `FP_WORD_ONES;
    end else if (state == st_idle && req && op == op_program && !refuse) begin
      arr_wr = 1'b1;
    end
  end

  flash_array #(.WORDS(`FP_WORDS), .AW(AW)) u_array (
    .core_clk(core_clk),
    .wr_en(arr_wr),
    .wr_addr(arr_waddr),
    .wr_data(arr_wdata),
    .rd_en(state == st_idle && req && !refuse),
    .rd_addr(addr),
    .rd_data(arr_rdata)
  );

  // ------------------------------------------------------------------
  // answers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (state == st_idle) ? (req && !refuse && op != op_program) :
              (state == st_erase) ? (erase_ix != `FP_WORD_LAST_IX) : 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
      denied <= 1'b0;
      rdata <= `FP_ZERO_WORD;
      rd_pending <= 1'b0;
    end else begin
      done <= 1'b0;
      denied <= 1'b0;
      rd_pending <= 1'b0;
      if (state == st_idle && req) begin
        if (refuse) begin
          done <= 1'b1;
          denied <= 1'b1;
          rdata <= `FP_ZERO_WORD;
        end else if (op == op_program) begin
          done <= 1'b1;
        end else if (op != op_erase) begin
          rd_pending <= 1'b1;
        end
      end
      if (rd_pending) begin
        done <= 1'b1;
        rdata <= arr_rdata;
      end
      if (state == st_erase && erase_ix == `FP_WORD_LAST_IX) begin
        done <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_ro_no_write: assert property (
    (state == st_idle && req && (op == op_program || op == op_erase) && lvl == `FP_PROT_RO)
      |-> !arr_wr ##1 (denied && done && state == st_idle))
    else $error("write reached read-only unit");
  a_xo_hidden: assert property (
    (state == st_idle && req && (op == op_data_read || op == op_debug_read)
      && lvl == `FP_PROT_XO) |=> denied && rdata == `FP_ZERO_WORD)
    else $error("execute-only data leaked");
  a_xo_fetch: assert property (
    (state == st_idle && req && op == op_fetch) |=> !denied ##1 (done && !denied))
    else $error("fetch refused");
  a_xo_no_write: assert property (
    (state == st_idle && req && lvl == `FP_PROT_XO && op == op_erase) |=> state == st_idle)
    else $error("erase began on execute-only unit");
  a_erase_ones: assert property (
    (state == st_erase) |-> arr_wr && arr_wdata == `FP_WORD_ONES)
    else $error("erase wrote non-ones");
  a_erase_bound: assert property (
    (state == st_erase) |-> arr_waddr[AW-1:`FP_BLOCK_LSB] == erase_block)
    else $error("erase left its block");
  a_erase_len: assert property (
    ($rose(state == st_erase)) |-> ##255 (state == st_erase && erase_ix == `FP_WORD_LAST_IX)
      ##1 (done && state == st_idle))
    else $error("erase length wrong");
  a_prot_take: assert property (
    prot_wr |=> prot[$past(prot_unit)] == $past(prot_level))
    else $error("protection not stored");
  a_denied_done: assert property (
    denied |-> done && !$past(arr_wr))
    else $error("denied without done");
  a_unit_pair: assert property (
    prot_wr |=> prot[$past(prot_unit) ^ 5'h01] == $past(prot[prot_unit ^ 5'h01]))
    else $error("neighbour unit changed");

  c_denied: cover property (denied);
  c_erase_done: cover property ($fell(state == st_erase));
  c_fetch_xo: cover property (state == st_idle && req && op == op_fetch
    && lvl == `FP_PROT_XO);
  c_program: cover property (arr_wr && state == st_idle);
endmodule
`default_nettype wire

/* hdl/flash_prot_cfg.svh */
// flash protection constants: array geometry, protection codes, timing
// assumes: included by the package and the design modules by bare name
`ifndef FLASH_PROT_CFG_SVH
`define FLASH_PROT_CFG_SVH

`define FP_WORDS        16384
`define FP_ADDR_W       14
`define FP_BLOCK_LSB    8
`define FP_BLOCK_W      6
`define FP_UNIT_LSB     9
`define FP_UNIT_W       5
`define FP_UNITS        32
`define FP_WORD_ONES    32'hffffffff
`define FP_ZERO_WORD    32'h00000000
`define FP_WORD_ZERO_IX 8'h00
`define FP_WORD_LAST_IX 8'hff
`define FP_PROT_OPEN    2'h0
`define FP_PROT_RO      2'h1
`define FP_PROT_XO      2'h2

`endif

/* hdl/flash_prot_pkg.sv */
// flash protection types: request kinds and protection levels
// assumes: the _cfg header defines the codes used here
`include "flash_prot_cfg.svh"

package flash_prot_pkg;
  typedef enum logic [2:0] {
    op_fetch = 3'h0,
    op_data_read = 3'h1,
    op_debug_read = 3'h2,
    op_program = 3'h3,
    op_erase = 3'h4
  } flash_op_e;

  typedef logic [1:0] prot_level_t;
endpackage

/* tb/core_bus_model.sv */
// core bus model: fetch, data and debug requester in front of the flash
// assumes: one request at a time, each answered by a done pulse
`timescale 1ns/1ps
`default_nettype none
module core_bus_model
  import flash_prot_pkg::*;
(
  input wire logic core_clk,
  input wire logic busy,
  input wire logic done,
  input wire logic denied,
  input wire logic [31:0] rdata,
  output logic req,
  output var flash_op_e op,
  output logic [13:0] addr,
  output logic [31:0] wdata
);
  initial begin
    req = 1'b0;
    op = op_fetch;
    addr = 14'h0000;
    wdata = 32'h0;
  end
  // released addr and wdata show the inverse (op holds), so a design that samples them late sees junk
  task automatic access(input flash_op_e o, input logic [13:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic dn, output bit ok, output int bc);
    int n;
    @(posedge core_clk);
    req <= 1'b1;
    op <= o;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    req <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    ok = 1'b0;
    bc = 0;
    // program and refusal answer at the take edge itself, so look before waiting
    for (n = 0; n < 300 && !ok; n++) begin
      #1;
      ok = (done === 1'b1);
      if (busy === 1'b1) begin
        bc++;
      end
      if (!ok) begin
        @(posedge core_clk);
      end
    end
    rd = rdata;
    dn = denied;
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// testbench: erase and protection scenarios through the core bus model
// assumes: package and design compiled first; 50 MHz core clock
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_cfg.svh"
module tb_top;
  import flash_prot_pkg::*;
  logic core_clk, resetn, req, prot_wr, busy, done, denied;
  flash_op_e op;
  logic [13:0] addr;
  logic [31:0] wdata, rdata;
  logic [4:0] prot_unit;
  prot_level_t prot_level;
  int error_cnt, checks;
  flash_block_protection dut (.core_clk(core_clk), .resetn(resetn),
    .req(req), .op(op), .addr(addr), .wdata(wdata), .prot_wr(prot_wr),
    .prot_unit(prot_unit), .prot_level(prot_level), .busy(busy),
    .done(done), .denied(denied), .rdata(rdata));
  core_bus_model u_core (.core_clk(core_clk), .busy(busy), .done(done), .denied(denied),
    .rdata(rdata), .req(req), .op(op), .addr(addr), .wdata(wdata));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one access; read data is judged only where it is defined
  task automatic go(input flash_op_e o, input logic [13:0] a,
                    input logic [31:0] d, input logic edn, input logic [31:0] erd);
    logic [31:0] rd;
    logic dn;
    bit ok;
    int bc;
    int ebc;
    u_core.access(o, a, d, rd, dn, ok, bc);
    ebc = (edn || o == op_program) ? 0 : ((o == op_erase) ? 256 : 1);
    if (!ok) begin
      error_cnt++;
      $display("ERROR %0t: no answer", $time);
      finish_test();
    end else begin
      check({31'h0, dn}, {31'h0, edn});
      check(bc, ebc);
      if (edn || o == op_fetch || o == op_data_read || o == op_debug_read) begin
        check(rd, erd);
      end
    end
  endtask
  task automatic set_prot(input logic [4:0] u, input prot_level_t l);
    @(posedge core_clk);
    prot_wr <= 1'b1;
    prot_unit <= u;
    prot_level <= l;
    @(posedge core_clk);
    prot_wr <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_erase();
    go(op_erase, 14'h0000, 32'h0, 1'b0, 32'h0);
    go(op_program, 14'h0010, 32'h5a5a0f0f, 1'b0, 32'h0);
    go(op_erase, 14'h0100, 32'h0, 1'b0, 32'h0);
    go(op_data_read, 14'h0010, 32'h0, 1'b0, 32'h5a5a0f0f);
    go(op_data_read, 14'h0000, 32'h0, 1'b0, 32'hffffffff);
    go(op_fetch, 14'h01ff, 32'h0, 1'b0, 32'hffffffff);
    $display("test erase done");
  endtask
  task automatic t_ro();
    go(op_erase, 14'h0200, 32'h0, 1'b0, 32'h0);
    go(op_program, 14'h0300, 32'h12345678, 1'b0, 32'h0);
    set_prot(5'h01, `FP_PROT_RO);
    go(op_program, 14'h0300, 32'h0, 1'b1, 32'h0);
    go(op_erase, 14'h0300, 32'h0, 1'b1, 32'h0);
    go(op_data_read, 14'h0300, 32'h0, 1'b0, 32'h12345678);
    go(op_debug_read, 14'h0200, 32'h0, 1'b0, 32'hffffffff);
    go(op_program, 14'h0400, 32'h0badf00d, 1'b0, 32'h0);
    $display("test read-only done");
  endtask
  task automatic t_xo();
    set_prot(5'h02, `FP_PROT_XO);
    go(op_fetch, 14'h0400, 32'h0, 1'b0, 32'h0badf00d);
    go(op_data_read, 14'h0400, 32'h0, 1'b1, 32'h0);
    go(op_debug_read, 14'h05ff, 32'h0, 1'b1, 32'h0);
    go(op_program, 14'h0400, 32'h0, 1'b1, 32'h0);
    go(op_erase, 14'h0400, 32'h0, 1'b1, 32'h0);
    go(op_fetch, 14'h0400, 32'h0, 1'b0, 32'h0badf00d);
    go(flash_op_e'(3'h5), 14'h0000, 32'h0, 1'b1, 32'h0);
    set_prot(5'h02, `FP_PROT_OPEN);
    go(op_data_read, 14'h0400, 32'h0, 1'b0, 32'h0badf00d);
    $display("test execute-only done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    error_cnt = 0;
    checks = 0;
    resetn = 1'b0;
    prot_wr = 1'b0;
    prot_unit = 5'h00;
    prot_level = 2'h0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    t_erase();
    t_ro();
    t_xo();
    finish_test();
  end
endmodule
`default_nettype wire
